// file: verif/cpu_can_sfr_interface_test.sv
/* cpu_can_sfr_interface_test: register sequences on the bridge with expected values.
 * Assumes the core model on the far side; inputs change on the falling edge. */
`default_nettype none
module cpu_can_sfr_interface_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, wr, rd, bwr, brd, bwd, rsq, done, brdata, bval, cv, dst, busy, cwe, rv;
	logic cv_seen, ds_seen;
	logic [7:0] addr, wd, rdat, baddr, sta, cd, ram, crd, cwd;
	logic [4:0] irq, bufa, cad;
	logic [3:0] txc, rxc, dly;
	int n_mismatch, comparisons, cyc;
	csi_sfr_bridge dut_u (.clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_wdata(wd), .sfr_rdata(rdat), .sfr_rvalid(rv), .sfr_bit_addr(baddr),
		.sfr_bit_wr(bwr), .sfr_bit_rd(brd), .sfr_bit_wdata(bwd), .sfr_bit_rdata(brdata),
		.sfr_bit_rvalid(bval), .can_irq(irq), .can_status(sta), .can_reset_req(rsq),
		.dma_done(done), .cmd_data(cd), .cmd_valid(cv), .dma_start(dst), .dma_busy(busy),
		.dma_ram_addr(ram), .dma_buf_addr(bufa), .core_we(cwe), .core_addr(cad),
		.core_wdata(cwd), .core_rdata(crd), .tx_byte_count(txc), .rx_byte_count(rxc));
	csi_can_model far_u (.clk(clk), .rst_n(rst_n), .dma_start(dst), .dly(dly), .dma_done(done),
		.can_irq(irq), .can_status(sta), .core_we(cwe), .core_addr(cad), .core_wdata(cwd));
	// ****************************************
	// clock, timeout and bus tasks
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_mismatch = n_mismatch + 1;
			complete_run();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic sw(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1'b1;
		@(negedge clk) wr = 1'b0;
		// catch the one-cycle pulses, then let an edge pass before the next strobe
		cv_seen = cv;
		ds_seen = dst;
		@(negedge clk);
	endtask : sw
	// read: answer sampled one and a half cycles after the taking edge
	task automatic sr(input logic [7:0] a, input logic [7:0] exp, input logic ok);
		addr = a;
		rd = 1'b1;
		@(negedge clk) rd = 1'b0;
		@(negedge clk);
		chk("rvalid", {7'h0, rv}, {7'h0, ok});
		if (ok)
			chk("rdata", rdat, exp);
	endtask : sr
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rst_n, wr, rd, bwr, brd, bwd, rsq, addr, wd, baddr, n_mismatch, comparisons, cyc} = '0;
		dly = 4'h3;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		sr(8'hdb, 8'h64, 1'b1);
		sw(8'hdb, 8'h00);
		sr(8'hdb, 8'h40, 1'b1);
		sw(8'hdb, 8'h2c);
		sw(8'hda, 8'h11);
		sw(8'hda, 8'h22);
		sw(8'hda, 8'h33);
		sr(8'hdb, 8'h6f, 1'b1);
		sw(8'hdb, 8'h0c);
		sr(8'hda, 8'h11, 1'b1);
		sr(8'hda, 8'h11, 1'b1);
		sw(8'hdb, 8'h2d);
		sr(8'hda, 8'h22, 1'b1);
		sr(8'hda, 8'h33, 1'b1);
		sw(8'hdb, 8'h3f);
		sw(8'hda, 8'haa);
		sr(8'hdb, 8'h40, 1'b1);
		sw(8'hdb, 8'h5f);
		sr(8'hda, 8'haa, 1'b1);
		sw(8'hdb, 8'h0b);
		sw(8'hda, 8'h0a);
		chk("tx count", {4'h0, txc}, 8'h08);
		sw(8'hda, 8'he3);
		chk("tx count", {4'h0, txc}, 8'h03);
		chk("rx count", {4'h0, rxc}, 8'h05);
		chk("core read", crd, 8'h25);
		sr(8'hd9, 8'hf5, 1'b1);
		for (int i = 0; i < 8; i++) begin
			sw(8'hd9, 8'h01 << i);
			chk("command", cd, 8'h01 << i);
			chk("command valid", {7'h0, cv_seen}, 8'h01);
		end
		sw(8'hd8, 8'h81);
		chk("ram addr", ram, 8'h81);
		chk("no command", {7'h0, cv_seen}, 8'h00);
		sr(8'hd8, 8'h5a, 1'b1);
		for (int i = 0; i < 8; i++) begin
			baddr = 8'hd8 + 8'(i);
			brd = 1'b1;
			@(negedge clk) brd = 1'b0;
			chk("bit valid", {7'h0, bval}, 8'h01);
			chk("status bit", {7'h0, brdata}, {7'h0, sta[i]});
			@(negedge clk);
		end
		baddr = 8'hdf;
		bwr = 1'b1;
		@(negedge clk) bwr = 1'b0;
		@(negedge clk);
		chk("ram addr bit", ram, 8'h01);
		rsq = 1'b1;
		sw(8'hdb, 8'h8a);
		chk("refused busy", {6'h0, ds_seen, busy}, 8'h00);
		rsq = 1'b0;
		for (int k = 0; k < 2; k++) begin
			dly = (k == 0) ? 4'h1 : 4'hc;
			sw(8'hdb, 8'h8a);
			chk("busy", {1'h0, ds_seen, busy, bufa}, 8'h6a);
			sr(8'hdb, 8'h00, 1'b0);
			for (int t = 0; t < 40 && busy === 1'b1; t++)
				@(negedge clk);
			sr(8'hdb, 8'h4a, 1'b1);
		end
		complete_run();
	end
endmodule : cpu_can_sfr_interface_test
`default_nettype wire

// file: verif/csi_can_model.sv
/* csi_can_model: CAN core side, fixed interrupt and status levels, dma answers.
 * Assumes the bridge clock; dly sets how slowly a dma transfer ends. */
`default_nettype none
module csi_can_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       dma_start,
	input  wire logic [3:0] dly,
	output var  logic       dma_done,
	output var  logic [4:0] can_irq,
	output var  logic [7:0] can_status,
	output var  logic       core_we,
	output var  logic [4:0] core_addr,
	output var  logic [7:0] core_wdata
);
	// ****************************************
	// levels, one rx descriptor write, dma end
	// ****************************************
	logic [3:0] cnt_ff;
	logic [4:0] wait_ff;
	assign can_irq    = 5'h15;
	assign can_status = 8'h5a;
	assign core_addr  = csi_pkg::RX_DESC2_ADDR;
	assign core_wdata = 8'h25;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff   <= 4'h0;
			wait_ff  <= 5'h00;
			dma_done <= 1'b0;
			core_we  <= 1'b0;
		end else begin
			cnt_ff   <= (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
			core_we  <= (cnt_ff == 4'h2);
			dma_done <= (wait_ff == 5'h01);
			if (dma_start)
				wait_ff <= {1'b0, dly} + 5'h01;
			else if (wait_ff != 5'h00)
				wait_ff <= wait_ff - 5'h01;
		end
	end
endmodule : csi_can_model
`default_nettype wire

// file: verif/csi_sfr_props.sv
/* csi_sfr_props: port checker for the CPU to CAN register bridge.
 * Assumes one clock, synchronous active-low reset, bound to csi_sfr_bridge. */
`default_nettype none
module csi_sfr_props (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_rvalid,
	input wire logic [7:0] sfr_bit_addr,
	input wire logic       sfr_bit_rd,
	input wire logic       sfr_bit_rdata,
	input wire logic       sfr_bit_rvalid,
	input wire logic [7:0] can_status,
	input wire logic       can_reset_req,
	input wire logic       dma_done,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic       dma_start,
	input wire logic       dma_busy,
	input wire logic [7:0] dma_ram_addr,
	input wire logic [4:0] dma_buf_addr
);
	// ****************************************
	// taken requests and expected status bit
	// ****************************************
	logic take_rd, take_wr, take_bit, exp_bit_ff;
	assign take_rd  = sfr_rd && !sfr_wr && sfr_addr[7:2] == 6'h36 && !dma_busy;
	assign take_wr  = sfr_wr && sfr_addr[7:2] == 6'h36 && !dma_busy;
	assign take_bit = sfr_bit_rd && sfr_bit_addr[7:3] == 5'h1b && !dma_busy;
	always_ff @(posedge clk) begin
		exp_bit_ff <= can_status[sfr_bit_addr[2:0]];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_ptr_reset: assert property (rst_n && !$past(rst_n) |-> dma_buf_addr == 5'h04 && !dma_busy)
		else $error("pointer not at reset value");
	chk_read_latency: assert property (take_rd |-> ##2 sfr_rvalid)
		else $error("read answer missing");
	chk_rvalid_cause: assert property (sfr_rvalid |-> $past(take_rd, 2))
		else $error("read answer without request");
	chk_dma_start: assert property (take_wr && sfr_addr == 8'hdb && sfr_wdata[7] && !can_reset_req
		|=> dma_start && dma_busy)
		else $error("dma not started");
	chk_dma_refused: assert property (take_wr && sfr_addr == 8'hdb && can_reset_req |=> !dma_busy)
		else $error("dma started under reset request");
	chk_dma_done: assert property (dma_busy && dma_done |=> !dma_busy)
		else $error("dma busy after done");
	chk_cmd_pulse: assert property (take_wr && sfr_addr == 8'hd9 |=> cmd_valid && cmd_data == $past(sfr_wdata))
		else $error("command not passed on");
	chk_irq_rsvd: assert property (take_rd && sfr_addr == 8'hd9 |-> ##2 sfr_rdata[7:5] == 3'b111)
		else $error("interrupt view reserved bits low");
	chk_ram_addr: assert property (take_wr && sfr_addr == 8'hd8 |=> dma_ram_addr == $past(sfr_wdata))
		else $error("dma ram address not loaded");
	chk_bit_read: assert property (take_bit |=> sfr_bit_rvalid && sfr_bit_rdata == exp_bit_ff)
		else $error("status bit read wrong");
	chk_ptr_still: assert property (!sfr_wr && !sfr_rd |=> $stable(dma_buf_addr))
		else $error("pointer moved without access");
	cov_data_rd: cover property (take_rd && sfr_addr == 8'hda);
	cov_dma: cover property (dma_start ##[1:40] dma_done);
	cov_cmd: cover property (cmd_valid);
endmodule : csi_sfr_props
bind csi_sfr_bridge csi_sfr_props chk_u (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.sfr_rvalid(sfr_rvalid), .sfr_bit_addr(sfr_bit_addr), .sfr_bit_rd(sfr_bit_rd),
	.sfr_bit_rdata(sfr_bit_rdata), .sfr_bit_rvalid(sfr_bit_rvalid), .can_status(can_status),
	.can_reset_req(can_reset_req), .dma_done(dma_done), .cmd_valid(cmd_valid),
	.cmd_data(cmd_data), .dma_start(dma_start), .dma_busy(dma_busy),
	.dma_ram_addr(dma_ram_addr), .dma_buf_addr(dma_buf_addr));
`default_nettype wire

// file: verilog/csi_pkg.sv
/*
 * csi_pkg: constants shared by the CPU to CAN special function register bridge.
 * Assumes an 8-bit CPU special function register bus on the same clock as the block.
 */
// Notes on behaviour
// - pointer low five bits pick internal register
// - pointer resets to 64h, acceptance code
// - data port access hits the selected register
// - pointer bit 7 starts and tracks DMA
// - bit 5 auto increment, bit 6 reserved
// - reserved bits of pointer and control read one
// - control read returns CAN interrupt register
// - control write goes to command register
// - status register bit addresses DFh down D8h
// - data field from address 12, length coded
// - receive layout same, starting at 20
// - status read returns CAN status register
// - status write loads DMA RAM start address
// - auto increment bumps pointer after access
// - byte count is length code, 0 to 8
`default_nettype none

package csi_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [7:0] ADDR_STATUS_DMA   = 8'hd8;
	localparam logic [7:0] ADDR_IRQ_CMD      = 8'hd9;
	localparam logic [7:0] ADDR_DATA_PORT    = 8'hda;
	localparam logic [7:0] ADDR_POINTER      = 8'hdb;
	localparam logic [4:0] BIT_ADDR_BASE     = 5'h1b;   // d8h..dfh share upper five bits

	// ****************************************
	// pointer fields and reset values
	// ****************************************
	localparam int         PTR_DMA_BIT       = 7;
	localparam int         PTR_RSVD_BIT      = 6;
	localparam int         PTR_POINTER_AUTO_INCREMENT_BIT   = 5;
	localparam int         PTR_SEL_W         = 5;
	localparam logic [7:0] POINTER_RESET     = 8'h64;
	localparam logic [7:0] DMA_ADDR_RESET    = 8'h00;
	localparam logic [7:0] IRQ_RSVD_MASK     = 8'he0;   // bits 7..5 of the interrupt view

	// ****************************************
	// internal buffer layout
	// ****************************************
	localparam logic [4:0] TX_DESC2_ADDR     = 5'h0b;   // address 11
	localparam logic [4:0] TX_DATA_ADDR      = 5'h0c;   // address 12
	localparam logic [4:0] RX_DESC2_ADDR     = 5'h15;   // address 21
	localparam logic [4:0] RX_DATA_ADDR      = 5'h16;   // address 22
	localparam logic [3:0] MAX_BYTE_COUNT    = 4'h8;
	localparam int         MEM_DEPTH         = 32;

	// ****************************************
	// read pipeline state
	// ****************************************
	typedef enum logic [1:0] {
		CSI_RD_IDLE,
		CSI_RD_FETCH,
		CSI_RD_DONE
	} csi_rd_e;

endpackage : csi_pkg

`default_nettype wire

// file: verilog/csi_reg_mem.sv
/*
 * csi_reg_mem: the CAN controller internal register space, two ports.
 * Assumes both ports on one clock; port a (CPU side) wins a same-address write clash.
 */
`default_nettype none

module csi_reg_mem (
	input  wire logic       clk,
	input  wire logic       a_we,
	input  wire logic [4:0] a_addr,
	input  wire logic [7:0] a_wdata,
	output var  logic [7:0] a_rdata,
	input  wire logic       b_we,
	input  wire logic [4:0] b_addr,
	input  wire logic [7:0] b_wdata,
	output var  logic [7:0] b_rdata
);

	// ****************************************
	// storage
	// ****************************************
	logic [7:0] mem [csi_pkg::MEM_DEPTH];

	// write both ports, port a last so it wins a clash; read data registered
	always_ff @(posedge clk) begin
		if (b_we && !(a_we && a_addr == b_addr)) begin
			mem[b_addr] <= b_wdata;
		end
		if (a_we) begin
			mem[a_addr] <= a_wdata;
		end
		a_rdata <= mem[a_addr];
		b_rdata <= mem[b_addr];
	end

endmodule : csi_reg_mem

`default_nettype wire

// file: verilog/csi_sfr_bridge.sv
/*
 * csi_sfr_bridge: pointer, data port, control and status special function
 * registers between the CPU and the CAN controller internals and DMA logic.
 * Assumes CPU strobes are one-cycle pulses on clk, at most one access per cycle,
 * and that the CAN core answers dma_start with a dma_done pulse.
 */
`default_nettype none

module csi_sfr_bridge (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output var  logic [7:0] sfr_rdata,
	output var  logic       sfr_rvalid,
	input  wire logic [7:0] sfr_bit_addr,
	input  wire logic       sfr_bit_wr,
	input  wire logic       sfr_bit_rd,
	input  wire logic       sfr_bit_wdata,
	output var  logic       sfr_bit_rdata,
	output var  logic       sfr_bit_rvalid,
	input  wire logic [4:0] can_irq,
	input  wire logic [7:0] can_status,
	input  wire logic       can_reset_req,
	input  wire logic       dma_done,
	output var  logic [7:0] cmd_data,
	output var  logic       cmd_valid,
	output var  logic       dma_start,
	output var  logic       dma_busy,
	output var  logic [7:0] dma_ram_addr,
	output var  logic [4:0] dma_buf_addr,
	input  wire logic       core_we,
	input  wire logic [4:0] core_addr,
	input  wire logic [7:0] core_wdata,
	output var  logic [7:0] core_rdata,
	output var  logic [3:0] tx_byte_count,
	output var  logic [3:0] rx_byte_count
);

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0]     pointer_ff,   nxt_pointer;
	logic [7:0]     dma_addr_ff,  nxt_dma_addr;
	logic           dma_busy_ff,  nxt_dma_busy;
	logic           dma_start_ff, nxt_dma_start;
	logic [7:0]     cmd_data_ff,  nxt_cmd_data;
	logic           cmd_valid_ff, nxt_cmd_valid;
	logic [3:0]     tx_cnt_ff,    nxt_tx_cnt;
	logic [3:0]     rx_cnt_ff,    nxt_rx_cnt;
	csi_pkg::csi_rd_e rd_st_ff,   nxt_rd_st;
	logic [7:0]     rd_sel_ff,    nxt_rd_sel;
	logic [7:0]     rd_snap_ff,   nxt_rd_snap;
	logic [7:0]     rdata_ff,     nxt_rdata;
	logic           rvalid_ff,    nxt_rvalid;
	logic           bit_rdata_ff, nxt_bit_rdata;
	logic           bit_rvalid_ff, nxt_bit_rvalid;
	logic           hit_ptr;
	logic           hit_dat;
	logic           hit_cmd;
	logic           hit_sta;
	logic           wr_ok;
	logic           port_access;
	logic           bit_hit;
	logic           mem_we;
	logic [7:0]     mem_rdata;
	logic [7:0]     core_rdata_w;
	logic [7:0]     ptr_visible;

	// ****************************************
	// address decode
	// ****************************************
	// decode the four registers; CPU writes are held off while DMA runs
	always_comb begin
		hit_ptr = 1'b0;
		hit_dat = 1'b0;
		hit_cmd = 1'b0;
		hit_sta = 1'b0;
		if (sfr_addr == csi_pkg::ADDR_POINTER) begin
			hit_ptr = 1'b1;
		end else if (sfr_addr == csi_pkg::ADDR_DATA_PORT) begin
			hit_dat = 1'b1;
		end else if (sfr_addr == csi_pkg::ADDR_IRQ_CMD) begin
			hit_cmd = 1'b1;
		end else if (sfr_addr == csi_pkg::ADDR_STATUS_DMA) begin
			hit_sta = 1'b1;
		end
	end

	assign wr_ok       = sfr_wr && !dma_busy_ff;
	assign port_access = hit_dat && !dma_busy_ff && (sfr_wr || sfr_rd);
	assign mem_we      = hit_dat && wr_ok;
	assign bit_hit     = sfr_bit_addr[7:3] == csi_pkg::BIT_ADDR_BASE;
	assign ptr_visible = pointer_ff | (8'h01 << csi_pkg::PTR_RSVD_BIT);

	// ****************************************
	// internal register space
	// ****************************************
	// data port is a window onto the location picked by the pointer
	csi_reg_mem u_mem (
		.clk     (clk),
		.a_we    (mem_we),
		.a_addr  (pointer_ff[csi_pkg::PTR_SEL_W-1:0]),
		.a_wdata (sfr_wdata),
		.a_rdata (mem_rdata),
		.b_we    (core_we),
		.b_addr  (core_addr),
		.b_wdata (core_wdata),
		.b_rdata (core_rdata_w)
	);

	// ****************************************
	// pointer and DMA control
	// ****************************************
	// pointer writes, auto increment and the DMA start and finish
	always_comb begin
		nxt_pointer   = pointer_ff;
		nxt_dma_busy  = dma_busy_ff;
		nxt_dma_start = 1'b0;
		if (dma_busy_ff && dma_done) begin
			nxt_pointer[csi_pkg::PTR_DMA_BIT] = 1'b0;
			nxt_dma_busy = 1'b0;
		end
		if (hit_ptr && wr_ok) begin
			nxt_pointer = sfr_wdata;
			nxt_pointer[csi_pkg::PTR_RSVD_BIT] = 1'b1;
			if (sfr_wdata[csi_pkg::PTR_DMA_BIT] && !can_reset_req) begin
				nxt_dma_busy  = 1'b1;
				nxt_dma_start = 1'b1;
			end else begin
				nxt_pointer[csi_pkg::PTR_DMA_BIT] = 1'b0;
			end
		end else if (port_access && pointer_ff[csi_pkg::PTR_POINTER_AUTO_INCREMENT_BIT]) begin
			if (&pointer_ff[csi_pkg::PTR_SEL_W-1:0]) begin
				nxt_pointer[csi_pkg::PTR_POINTER_AUTO_INCREMENT_BIT:0] = 6'h00;
			end else begin
				nxt_pointer[csi_pkg::PTR_SEL_W-1:0] =
					pointer_ff[csi_pkg::PTR_SEL_W-1:0] + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pointer_ff   <= csi_pkg::POINTER_RESET;
			dma_busy_ff  <= 1'b0;
			dma_start_ff <= 1'b0;
		end else begin
			pointer_ff   <= nxt_pointer;
			dma_busy_ff  <= nxt_dma_busy;
			dma_start_ff <= nxt_dma_start;
		end
	end

	// ****************************************
	// command and DMA address
	// ****************************************
	// control writes pass to the command register; status writes load RAM address
	always_comb begin
		nxt_cmd_data  = cmd_data_ff;
		nxt_cmd_valid = 1'b0;
		nxt_dma_addr  = dma_addr_ff;
		if (hit_cmd && wr_ok) begin
			nxt_cmd_data  = sfr_wdata;
			nxt_cmd_valid = 1'b1;
		end
		if (hit_sta && wr_ok) begin
			nxt_dma_addr = sfr_wdata;
		end else if (bit_hit && sfr_bit_wr && !dma_busy_ff) begin
			nxt_dma_addr[sfr_bit_addr[2:0]] = sfr_bit_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_data_ff  <= 8'h00;
			cmd_valid_ff <= 1'b0;
			dma_addr_ff  <= csi_pkg::DMA_ADDR_RESET;
		end else begin
			cmd_data_ff  <= nxt_cmd_data;
			cmd_valid_ff <= nxt_cmd_valid;
			dma_addr_ff  <= nxt_dma_addr;
		end
	end

	// ****************************************
	// data byte counts
	// ****************************************
	// length codes are caught as descriptor byte 2 is written, clamped to eight
	always_comb begin
		nxt_tx_cnt = tx_cnt_ff;
		nxt_rx_cnt = rx_cnt_ff;
		if (core_we && core_addr == csi_pkg::TX_DESC2_ADDR) begin
			nxt_tx_cnt = (core_wdata[3:0] > csi_pkg::MAX_BYTE_COUNT) ?
				csi_pkg::MAX_BYTE_COUNT : core_wdata[3:0];
		end
		if (core_we && core_addr == csi_pkg::RX_DESC2_ADDR) begin
			nxt_rx_cnt = (core_wdata[3:0] > csi_pkg::MAX_BYTE_COUNT) ?
				csi_pkg::MAX_BYTE_COUNT : core_wdata[3:0];
		end
		if (mem_we && pointer_ff[4:0] == csi_pkg::TX_DESC2_ADDR) begin
			nxt_tx_cnt = (sfr_wdata[3:0] > csi_pkg::MAX_BYTE_COUNT) ?
				csi_pkg::MAX_BYTE_COUNT : sfr_wdata[3:0];
		end
		if (mem_we && pointer_ff[4:0] == csi_pkg::RX_DESC2_ADDR) begin
			nxt_rx_cnt = (sfr_wdata[3:0] > csi_pkg::MAX_BYTE_COUNT) ?
				csi_pkg::MAX_BYTE_COUNT : sfr_wdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_cnt_ff <= 4'h0;
			rx_cnt_ff <= 4'h0;
		end else begin
			tx_cnt_ff <= nxt_tx_cnt;
			rx_cnt_ff <= nxt_rx_cnt;
		end
	end

	// ****************************************
	// byte read pipeline
	// ****************************************
	// cycle 1 snapshots the view and waits on memory, cycle 2 presents data
	always_comb begin
		nxt_rd_st   = csi_pkg::CSI_RD_IDLE;
		nxt_rd_sel  = rd_sel_ff;
		nxt_rd_snap = rd_snap_ff;
		nxt_rdata   = rdata_ff;
		nxt_rvalid  = 1'b0;
		case (rd_st_ff)
			csi_pkg::CSI_RD_FETCH: begin
				nxt_rd_st  = csi_pkg::CSI_RD_DONE;
				nxt_rvalid = 1'b1;
				if (rd_sel_ff == csi_pkg::ADDR_DATA_PORT) begin
					nxt_rdata = mem_rdata;
				end else begin
					nxt_rdata = rd_snap_ff;
				end
			end
			default: begin
				nxt_rd_st = csi_pkg::CSI_RD_IDLE;
			end
		endcase
		if (sfr_rd && !sfr_wr && !dma_busy_ff &&
			(hit_ptr || hit_dat || hit_cmd || hit_sta)) begin
			nxt_rd_st  = csi_pkg::CSI_RD_FETCH;
			nxt_rd_sel = sfr_addr;
			if (hit_ptr) begin
				nxt_rd_snap = ptr_visible;
			end else if (hit_cmd) begin
				nxt_rd_snap = csi_pkg::IRQ_RSVD_MASK | {3'h0, can_irq};
			end else begin
				nxt_rd_snap = can_status;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_st_ff   <= csi_pkg::CSI_RD_IDLE;
			rd_sel_ff  <= 8'h00;
			rd_snap_ff <= 8'h00;
			rdata_ff   <= 8'h00;
			rvalid_ff  <= 1'b0;
		end else begin
			rd_st_ff   <= nxt_rd_st;
			rd_sel_ff  <= nxt_rd_sel;
			rd_snap_ff <= nxt_rd_snap;
			rdata_ff   <= nxt_rdata;
			rvalid_ff  <= nxt_rvalid;
		end
	end

	// ****************************************
	// bit reads of the status register
	// ****************************************
	// a bit read returns one status bit on the next cycle
	always_comb begin
		nxt_bit_rdata  = bit_rdata_ff;
		nxt_bit_rvalid = 1'b0;
		if (sfr_bit_rd && bit_hit && !dma_busy_ff) begin
			nxt_bit_rdata  = can_status[sfr_bit_addr[2:0]];
			nxt_bit_rvalid = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_rdata_ff  <= 1'b0;
			bit_rvalid_ff <= 1'b0;
		end else begin
			bit_rdata_ff  <= nxt_bit_rdata;
			bit_rvalid_ff <= nxt_bit_rvalid;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// every output is a flip-flop
	assign sfr_rdata      = rdata_ff;
	assign sfr_rvalid     = rvalid_ff;
	assign sfr_bit_rdata  = bit_rdata_ff;
	assign sfr_bit_rvalid = bit_rvalid_ff;
	assign cmd_data       = cmd_data_ff;
	assign cmd_valid      = cmd_valid_ff;
	assign dma_start      = dma_start_ff;
	assign dma_busy       = dma_busy_ff;
	assign dma_ram_addr   = dma_addr_ff;
	assign dma_buf_addr   = pointer_ff[csi_pkg::PTR_SEL_W-1:0];
	assign core_rdata     = core_rdata_w;
	assign tx_byte_count  = tx_cnt_ff;
	assign rx_byte_count  = rx_cnt_ff;

endmodule : csi_sfr_bridge

`default_nettype wire
